//--- bench/dgp_pin_model.sv
// board circuitry that loads and drives the gpio pins
module dgp_pin_model (
   input wire logic [7:0] pa_pin_out,
   input wire logic [7:0] pa_pin_oe,
   input wire logic [4:0] pb_pin_out,
   input wire logic [4:0] pb_pin_oe,
   input wire logic [7:0] pa_ext,
   input wire logic [7:0] pa_fight,
   input wire logic [4:0] pb_ext,
   output logic [7:0] pa_pin_in,
   output logic [4:0] pb_pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // a fighting source beats the driver, so contention can be staged
   assign pa_pin_in = (pa_pin_oe & ~pa_fight & pa_pin_out)
      | ((~pa_pin_oe | pa_fight) & pa_ext);
   assign pb_pin_in = (pb_pin_oe & pb_pin_out) | (~pb_pin_oe & pb_ext);
endmodule

//--- bench/dgp_port_monitor.sv
// assertion checker for the dual gpio port block
module dgp_port_monitor (
   input wire logic ref_clk,
   input wire logic resetn,
   input dgp_pkg::dgp_bus_req_t bus_req,
   input wire logic [7:0] bus_rdata,
   input dgp_pkg::dgp_timer_evt_t timer_evt,
   input wire logic [7:0] pa_pin_in,
   input wire logic [7:0] pa_pin_out,
   input wire logic [7:0] pa_pin_oe,
   input wire logic [4:0] pb_pin_in,
   input wire logic [4:0] pb_pin_out,
   input wire logic [4:0] pb_pin_oe,
   input wire logic [7:0] pa_schmitt_en,
   input wire logic [4:0] pb_schmitt_en,
   input dgp_pkg::dgp_special_t special
);
   timeunit 1ns;
   timeprecision 1ps;
   // ========
   // shadow of the control registers, rebuilt from bus writes
   logic [7:0] a_dir, a_sfr, a_od;
   logic [4:0] b_dir, b_sfr;
   logic timer_toggle_output_on, comp_en;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         {a_dir, a_sfr, b_dir, b_sfr} <= '0;
      end else if (bus_req.wr) begin
         case (bus_req.addr)
            8'hd2: a_dir <= bus_req.wdata;
            8'hd3: a_sfr <= bus_req.wdata;
            8'hd6: b_dir <= bus_req.wdata[4:0];
            8'hd7: b_sfr <= bus_req.wdata[4:0];
            default: ;
         endcase
      end
   end
   assign a_od = a_dir & a_sfr;
   assign timer_toggle_output_on = b_dir[1] & b_sfr[1];
   assign comp_en = b_sfr[3] & b_sfr[4];
   // ========
   // assertions
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   rdata_idle_a: assert property (
      !$past(bus_req.rd) |-> bus_rdata == 8'h00)
      else $error("read data outside answer cycle");
   dir_readback_a: assert property (
      bus_req.rd && bus_req.addr == 8'hd2 |=> bus_rdata == $past(a_dir))
      else $error("direction read back wrong");
   input_off_a: assert property (
      (pa_pin_oe & pa_schmitt_en) == 8'h00 &&
      (pb_pin_oe & pb_schmitt_en) == 5'h00)
      else $error("schmitt enabled on driven pin");
   pb_enable_a: assert property (
      1 |=> pb_pin_oe == $past(b_dir))
      else $error("port b enable differs from direction");
   open_drain_a: assert property (
      1 |=> (pa_pin_out & $past(a_od)) == 8'h00)
      else $error("open drain pin driven high");
   reset_quiet_a: assert property (
      $rose(resetn) |-> pa_pin_oe == 8'h00 && pb_pin_oe == 5'h00)
      else $error("pin driven after reset");
   timer_toggle_output_toggle_a: assert property (
      timer_evt.t0_end && !timer_evt.pwm_mode && timer_toggle_output_on ##1 timer_toggle_output_on
      |=> pb_pin_out[1] != $past(pb_pin_out[1]))
      else $error("timer pin did not toggle");
   pwm_high_a: assert property (
      timer_evt.pwm_mode && timer_evt.pwm_high_end && timer_toggle_output_on ##1 timer_toggle_output_on
      |=> !pb_pin_out[1])
      else $error("timer pin not low after high time");
   pwm_low_a: assert property (
      timer_evt.pwm_mode && timer_evt.pwm_low_end && !timer_evt.pwm_high_end
      && timer_toggle_output_on ##1 timer_toggle_output_on |=> pb_pin_out[1])
      else $error("timer pin not high after low time");
   comp_on_a: assert property (
      1 |=> special.comparator_on == $past(comp_en))
      else $error("comparator enable wrong");
endmodule

bind dgp_port dgp_port_monitor u_dgp_port_monitor (
   .ref_clk(ref_clk), .resetn(resetn), .bus_req(bus_req),
   .bus_rdata(bus_rdata), .timer_evt(timer_evt), .pa_pin_in(pa_pin_in),
   .pa_pin_out(pa_pin_out), .pa_pin_oe(pa_pin_oe), .pb_pin_in(pb_pin_in),
   .pb_pin_out(pb_pin_out), .pb_pin_oe(pb_pin_oe),
   .pa_schmitt_en(pa_schmitt_en), .pb_schmitt_en(pb_schmitt_en),
   .special(special)
);

//--- bench/test_dgp_port.sv
// self-checking bench for the dual gpio port block
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   err_total++; $display("wrong value %s exp %h got %h", n, e, g); end end
module test_dgp_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, resetn;
   dgp_pkg::dgp_bus_req_t bus_req;
   dgp_pkg::dgp_timer_evt_t timer_evt;
   dgp_pkg::dgp_special_t special;
   logic [7:0] bus_rdata, pa_pin_in, pa_pin_out, pa_pin_oe, pa_schmitt_en;
   logic [7:0] pa_ext, pa_fight;
   logic [4:0] pb_pin_in, pb_pin_out, pb_pin_oe, pb_schmitt_en, pb_ext;
   int err_total = 0;
   int cmp_count = 0;
   dgp_port u_dgp_port (
      .ref_clk(ref_clk), .resetn(resetn), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .timer_evt(timer_evt), .pa_pin_in(pa_pin_in),
      .pa_pin_out(pa_pin_out), .pa_pin_oe(pa_pin_oe), .pb_pin_in(pb_pin_in),
      .pb_pin_out(pb_pin_out), .pb_pin_oe(pb_pin_oe),
      .pa_schmitt_en(pa_schmitt_en), .pb_schmitt_en(pb_schmitt_en),
      .special(special));
   dgp_pin_model u_dgp_pin_model (
      .pa_pin_out(pa_pin_out), .pa_pin_oe(pa_pin_oe), .pb_pin_out(pb_pin_out),
      .pb_pin_oe(pb_pin_oe), .pa_ext(pa_ext), .pa_fight(pa_fight),
      .pb_ext(pb_ext), .pa_pin_in(pa_pin_in), .pb_pin_in(pb_pin_in));
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // ========
   // bus and event drivers
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.wr <= 1'b1;
      @(posedge ref_clk);
      bus_req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge ref_clk);
      bus_req.rd <= 1'b0;
      #1;
      `CHK("read data", e, bus_rdata)
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // pulse is one cycle; the pin shows it one edge after it is taken
   task automatic pulse(input logic [2:0] k);
      @(posedge ref_clk);
      {timer_evt.pwm_high_end, timer_evt.pwm_low_end, timer_evt.t0_end} <= k;
      @(posedge ref_clk);
      {timer_evt.pwm_high_end, timer_evt.pwm_low_end, timer_evt.t0_end}
         <= 3'h0;
      tick(1);
   endtask
   // ========
   // scenarios
   task automatic t_reset;
      rd(8'hd2, 8'h00);
      rd(8'hd6, 8'h00);
      rd(8'hd3, 8'h00);
      rd(8'hd7, 8'h00);
      rd(8'hd0, 8'h5a);
      rd(8'hd4, 8'h13);
      $display("test reset done");
   endtask
   task automatic t_input;
      wr(8'hd0, 8'hff);
      rd(8'hd0, 8'h5a);
      wr(8'hd1, 8'hc3);
      wr(8'hd2, 8'h0f);
      wr(8'hd0, 8'h00);
      rd(8'hd0, 8'h50);
      wr(8'hd8, 8'hff);
      rd(8'hd8, 8'h00);
      $display("test input done");
   endtask
   task automatic t_drive;
      tick(1);
      `CHK("a enable", 8'h0f, pa_pin_oe)
      `CHK("a drive", 8'h03, pa_pin_out & pa_pin_oe)
      `CHK("a schmitt", 8'hf0, pa_schmitt_en)
      @(posedge ref_clk);
      pa_fight <= 8'h01;
      rd(8'hd1, 8'hc3);
      @(posedge ref_clk);
      pa_fight <= 8'h00;
      wr(8'hd3, 8'h01);
      tick(1);
      `CHK("a released", 8'h0e, pa_pin_oe)
      wr(8'hd1, 8'hc2);
      tick(1);
      `CHK("a sinking", 8'h0f, pa_pin_oe)
      `CHK("a low", 8'h02, pa_pin_out & pa_pin_oe)
      $display("test drive done");
   endtask
   task automatic t_portb;
      wr(8'hd5, 8'hff);
      wr(8'hd6, 8'h15);
      tick(1);
      `CHK("b enable", 5'h15, pb_pin_oe)
      `CHK("b schmitt", 5'h0a, pb_schmitt_en)
      `CHK("b drive", 5'h15, pb_pin_out & pb_pin_oe)
      rd(8'hd5, 8'h1f);
      $display("test port b done");
   endtask
   task automatic t_timer;
      wr(8'hd7, 8'h00);
      wr(8'hd6, 8'h02);
      wr(8'hd7, 8'h02);
      tick(1);
      `CHK("timer pin", 1'b0, pb_pin_out[1])
      // equal spacing of the pulses gives equal high and low times
      for (int i = 0; i < 4; i++) begin
         pulse(3'h1);
         `CHK("timer pin", ~i[0], pb_pin_out[1])
      end
      @(posedge ref_clk);
      timer_evt.pwm_mode <= 1'b1;
      // start from a low pin so every step moves or must hold the level
      pulse(3'h2);
      `CHK("pwm pin", 1'b1, pb_pin_out[1])
      pulse(3'h4);
      `CHK("pwm pin", 1'b0, pb_pin_out[1])
      pulse(3'h2);
      `CHK("pwm pin", 1'b1, pb_pin_out[1])
      pulse(3'h1);
      `CHK("pwm pin", 1'b1, pb_pin_out[1])
      pulse(3'h6);
      `CHK("pwm pin", 1'b0, pb_pin_out[1])
      @(posedge ref_clk);
      timer_evt.pwm_mode <= 1'b0;
      wr(8'hd6, 8'h00);
      tick(1);
      `CHK("timer enable", 1'b0, pb_pin_oe[1])
      wr(8'hd7, 8'h19);
      tick(4);
      `CHK("special", 5'h15, special)
      $display("test timer done");
   endtask
   // ========
   // run control
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      wrap_up();
   end
   initial begin
      resetn = 1'b0;
      bus_req = '0;
      timer_evt = '0;
      pa_ext = 8'h5a;
      pa_fight = 8'h00;
      pb_ext = 5'h13;
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      t_reset();
      t_input();
      t_drive();
      t_portb();
      t_timer();
      wrap_up();
   end
endmodule

//--- core/dgp_defines.svh
// constants of the dual port gpio block with timer toggle output
`ifndef DGP_DEFINES_SVH
`define DGP_DEFINES_SVH

`define DGP_ADDR_W 8
`define DGP_DATA_W 8
`define DGP_PA_W 8
`define DGP_PB_W 5

`define DGP_OFS_PA_IN 8'hd0
`define DGP_OFS_PA_OUT 8'hd1
`define DGP_OFS_PA_DIR 8'hd2
`define DGP_OFS_PA_SFR 8'hd3
`define DGP_OFS_PB_IN 8'hd4
`define DGP_OFS_PB_OUT 8'hd5
`define DGP_OFS_PB_DIR 8'hd6
`define DGP_OFS_PB_SFR 8'hd7

`define DGP_PB_STOP_BIT 0
`define DGP_PB_TIMER_TOGGLE_OUTPUT_BIT 1
`define DGP_PB_IRQ_BIT 2
`define DGP_PB_CREF_BIT 3
`define DGP_PB_CSIG_BIT 4

`define DGP_RST_DIR 8'h00
`define DGP_RST_SFR 8'h00
`define DGP_RST_IN 8'h00
`define DGP_RST_TOGGLE 1'b0
`define DGP_RST_RDATA 8'h00

`endif

//--- core/dgp_pkg.sv
// types shared by the dual port gpio block
package dgp_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dgp_bus_req_t;

   typedef struct packed {
      logic t0_end;
      logic pwm_mode;
      logic pwm_high_end;
      logic pwm_low_end;
   } dgp_timer_evt_t;

   typedef struct packed {
      logic stop_recovery;
      logic pin_two_irq;
      logic comparator_on;
      logic comparator_ref;
      logic comparator_sig;
   } dgp_special_t;
endpackage

//--- core/dgp_port.sv
// dual gpio port block: register file, pin drive and timer toggle output
//
// Summary of operation
// - timer output on port b pin one needs direction output and special bit.
// - outside pwm mode each timer zero end-of-count inverts the toggle flip-flop on pin one.
// - continuous timer zero reloads give equal high and low pin times.
// - in pwm mode end of high time drives low, end of low drives high unless high also ends.
// - thirteen lines: eight-bit port a plus a smaller port b.
// - port b has five lines, each direction set independently.
// - each register bit affects only the pin at its own position.
// - port a special bit selects open-drain for output pins.
// - input pins pass two flip-flops before the input value register.
// - output pins are driven from their output value bit.
// - the unused register bit of a pin keeps its value, no effect.
// - input register write is stored, then replaced next cycle if input.
// - input register bit of output pins keeps the software value.
// - output value register reads return held contents despite contention.
// - input schmitt-trigger disabled while the pin is an output.
// - port registers accessed in any order, at any time.
// - port b special bits enable recovery, timer, irq, comparator functions.
// - full reset clears directions to inputs, output values kept.
// - full reset clears both special function registers to zero.
// - recovery and watchdog events leave port control registers alone.
`include "dgp_defines.svh"

module dgp_port (
   input wire logic ref_clk,
   input wire logic resetn,
   input dgp_pkg::dgp_bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   input dgp_pkg::dgp_timer_evt_t timer_evt,
   input wire logic [7:0] pa_pin_in,
   output logic [7:0] pa_pin_out,
   output logic [7:0] pa_pin_oe,
   input wire logic [4:0] pb_pin_in,
   output logic [4:0] pb_pin_out,
   output logic [4:0] pb_pin_oe,
   output logic [7:0] pa_schmitt_en,
   output logic [4:0] pb_schmitt_en,
   output dgp_pkg::dgp_special_t special
);

   // ==========================================================
   // register storage
   // ==========================================================
   logic [7:0] port_a_input_value;
   logic [7:0] port_a_output_value;
   logic [7:0] port_a_direction;
   logic [7:0] port_a_special_select;
   logic [4:0] port_b_input_value;
   logic [4:0] port_b_output_value;
   logic [4:0] port_b_direction;
   logic [4:0] port_b_special_select;

   logic [7:0] pa_sync1;
   logic [7:0] pa_sync2;
   logic [4:0] pb_sync1;
   logic [4:0] pb_sync2;
   logic timer_toggle_output;

   logic wr_pa_in;
   logic wr_pa_out;
   logic wr_pa_dir;
   logic wr_pa_sfr;
   logic wr_pb_in;
   logic wr_pb_out;
   logic wr_pb_dir;
   logic wr_pb_sfr;

   // every register is reachable at any time, no access ordering
   assign wr_pa_in = bus_req.wr && bus_req.addr == `DGP_OFS_PA_IN;
   assign wr_pa_out = bus_req.wr && bus_req.addr == `DGP_OFS_PA_OUT;
   assign wr_pa_dir = bus_req.wr && bus_req.addr == `DGP_OFS_PA_DIR;
   assign wr_pa_sfr = bus_req.wr && bus_req.addr == `DGP_OFS_PA_SFR;
   assign wr_pb_in = bus_req.wr && bus_req.addr == `DGP_OFS_PB_IN;
   assign wr_pb_out = bus_req.wr && bus_req.addr == `DGP_OFS_PB_OUT;
   assign wr_pb_dir = bus_req.wr && bus_req.addr == `DGP_OFS_PB_DIR;
   assign wr_pb_sfr = bus_req.wr && bus_req.addr == `DGP_OFS_PB_SFR;

   // ==========================================================
   // control registers
   // ==========================================================
   // only the full device reset clears these; recovery and watchdog
   // events do not reach this block
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         port_a_direction <= `DGP_RST_DIR;
      end else begin
         if (wr_pa_dir) begin
            port_a_direction <= bus_req.wdata;
         end
      end
   end

   // port b keeps five bits; upper write data bits are dropped
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         port_b_direction <= 5'(`DGP_RST_DIR);
      end else begin
         if (wr_pb_dir) begin
            port_b_direction <= bus_req.wdata[4:0];
         end
      end
   end

   // cleared on full reset so no special function acts on stale bits
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         port_a_special_select <= `DGP_RST_SFR;
      end else begin
         if (wr_pa_sfr) begin
            port_a_special_select <= bus_req.wdata;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         port_b_special_select <= 5'(`DGP_RST_SFR);
      end else begin
         if (wr_pb_sfr) begin
            port_b_special_select <= bus_req.wdata[4:0];
         end
      end
   end

   // output values survive reset on purpose, so no reset branch; the
   // pins are inputs during reset, so the unknown start is harmless
   always_ff @(posedge ref_clk) begin
      if (wr_pa_out) begin
         port_a_output_value <= bus_req.wdata;
      end
      if (wr_pb_out) begin
         port_b_output_value <= bus_req.wdata[4:0];
      end
   end

   // ==========================================================
   // input synchronisers
   // ==========================================================
   // stage one is gated by the inverted direction bit so output pins do
   // not toggle the input path
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pa_sync1 <= `DGP_RST_IN;
         pa_sync2 <= `DGP_RST_IN;
         pb_sync1 <= 5'(`DGP_RST_IN);
         pb_sync2 <= 5'(`DGP_RST_IN);
      end else begin
         pa_sync1 <= pa_pin_in & ~port_a_direction;
         pa_sync2 <= pa_sync1;
         pb_sync1 <= pb_pin_in & ~port_b_direction;
         pb_sync2 <= pb_sync1;
      end
   end

   // ==========================================================
   // input value registers
   // ==========================================================
   // a write is stored for one cycle; input bits are then
   // refreshed from the synchroniser, output bits keep it
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         port_a_input_value <= `DGP_RST_IN;
      end else begin
         for (int i = 0; i < `DGP_PA_W; i++) begin
            if (wr_pa_in) begin
               port_a_input_value[i] <= bus_req.wdata[i];
            end else if (!port_a_direction[i]) begin
               port_a_input_value[i] <= pa_sync2[i];
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         port_b_input_value <= 5'(`DGP_RST_IN);
      end else begin
         for (int i = 0; i < `DGP_PB_W; i++) begin
            if (wr_pb_in) begin
               port_b_input_value[i] <= bus_req.wdata[i];
            end else if (!port_b_direction[i]) begin
               port_b_input_value[i] <= pb_sync2[i];
            end
            // output bits hold the last software value
         end
      end
   end

   // ==========================================================
   // timer toggle flip-flop
   // ==========================================================
   // in pwm mode the half-period ends set the level explicitly,
   // so the waveform cannot drift out of phase with the timer
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         timer_toggle_output <= `DGP_RST_TOGGLE;
      end else if (timer_evt.pwm_mode) begin
         if (timer_evt.pwm_high_end) begin
            timer_toggle_output <= 1'b0;
         end else if (timer_evt.pwm_low_end) begin
            timer_toggle_output <= 1'b1;
         end
      end else if (timer_evt.t0_end) begin
         // same reload each time gives a 50-percent duty cycle
         timer_toggle_output <= ~timer_toggle_output;
      end
   end

   // ==========================================================
   // pin drive, one generate per pin position
   // ==========================================================
   logic [7:0] next_pa_out;
   logic [7:0] next_pa_oe;
   logic [4:0] next_pb_out;
   logic [4:0] next_pb_oe;

   genvar g;
   generate
      for (g = 0; g < `DGP_PA_W; g++) begin : gen_pa
         // open-drain only ever pulls low; a one releases the pin
         always_comb begin
            if (port_a_special_select[g]) begin
               next_pa_out[g] = 1'b0;
               next_pa_oe[g] = port_a_direction[g] &
                               ~port_a_output_value[g];
            end else begin
               next_pa_out[g] = port_a_output_value[g];
               next_pa_oe[g] = port_a_direction[g];
            end
         end
      end
      for (g = 0; g < `DGP_PB_W; g++) begin : gen_pb
         always_comb begin
            next_pb_oe[g] = port_b_direction[g];
            if (g == `DGP_PB_TIMER_TOGGLE_OUTPUT_BIT && port_b_special_select[g]) begin
               next_pb_out[g] = timer_toggle_output;
            end else begin
               next_pb_out[g] = port_b_output_value[g];
            end
         end
      end
   endgenerate

   // registered drive costs a cycle but keeps decode glitches off the pins
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pa_pin_out <= 8'h00;
         pa_pin_oe <= 8'h00;
      end else begin
         pa_pin_out <= next_pa_out;
         pa_pin_oe <= next_pa_oe;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pb_pin_out <= 5'h00;
         pb_pin_oe <= 5'h00;
      end else begin
         pb_pin_out <= next_pb_out;
         pb_pin_oe <= next_pb_oe;
      end
   end

   // the buffer enable follows direction only, so a released open-drain
   // pin cannot be read back through its input path
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pa_schmitt_en <= 8'h00;
      end else begin
         pa_schmitt_en <= ~port_a_direction;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pb_schmitt_en <= 5'h00;
      end else begin
         pb_schmitt_en <= ~port_b_direction;
      end
   end

   // ==========================================================
   // port b special function outputs
   // ==========================================================
   // input functions only act while the pin is an input, which is
   // why software should arm the special bits last
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         special <= '0;
      end else begin
         special.stop_recovery <=
            port_b_special_select[`DGP_PB_STOP_BIT] &
            ~port_b_direction[`DGP_PB_STOP_BIT] &
            pb_sync2[`DGP_PB_STOP_BIT];
         special.pin_two_irq <=
            port_b_special_select[`DGP_PB_IRQ_BIT] &
            ~port_b_direction[`DGP_PB_IRQ_BIT] &
            pb_sync2[`DGP_PB_IRQ_BIT];
         special.comparator_on <=
            port_b_special_select[`DGP_PB_CREF_BIT] &
            port_b_special_select[`DGP_PB_CSIG_BIT];
         special.comparator_ref <=
            port_b_special_select[`DGP_PB_CREF_BIT] &
            pb_sync2[`DGP_PB_CREF_BIT];
         special.comparator_sig <=
            port_b_special_select[`DGP_PB_CSIG_BIT] &
            pb_sync2[`DGP_PB_CSIG_BIT];
      end
   end

   // ==========================================================
   // read data, one cycle after the read strobe
   // ==========================================================
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = `DGP_RST_RDATA;
      unique case (bus_req.addr)
         `DGP_OFS_PA_IN: next_rdata = port_a_input_value;
         `DGP_OFS_PA_OUT: next_rdata = port_a_output_value;
         `DGP_OFS_PA_DIR: next_rdata = port_a_direction;
         `DGP_OFS_PA_SFR: next_rdata = port_a_special_select;
         `DGP_OFS_PB_IN: next_rdata = {3'h0, port_b_input_value};
         `DGP_OFS_PB_OUT: next_rdata = {3'h0, port_b_output_value};
         `DGP_OFS_PB_DIR: next_rdata = {3'h0, port_b_direction};
         `DGP_OFS_PB_SFR: next_rdata = {3'h0, port_b_special_select};
         default: next_rdata = `DGP_RST_RDATA;
      endcase
   end

   // data stand only in the cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         bus_rdata <= `DGP_RST_RDATA;
      end else if (bus_req.rd) begin
         bus_rdata <= next_rdata;
      end else begin
         bus_rdata <= `DGP_RST_RDATA;
      end
   end

endmodule
